// File: csc_pkg.sv
// Constants for the charge sequence controller: register map, field
// positions, reset values, current tables and timing counts.
// Assumes a 40 MHz system clock.
`default_nettype none
package csc_pkg;
    localparam longint unsigned CLK_HZ = 40_000_000;
    // Register addresses and fields.
    localparam logic [2:0] A_CTL0 = 3'h0;
    localparam logic [2:0] A_CTL1 = 3'h1;
    localparam logic [2:0] A_CUR  = 3'h4;
    localparam logic [2:0] A_POST = 3'h7;
    localparam int B_KICK  = 7;
    localparam int B_CONN  = 3;
    localparam int B_TE    = 3;
    localparam int B_HZ    = 2;
    localparam int B_CEN   = 1;
    localparam int B_FIXLO = 7;
    localparam int B_PCEN  = 3;
    localparam int B_PCON  = 4;
    localparam logic [7:0] CTL1_RST = 8'h08;
    localparam logic [7:0] CUR_RST  = 8'h81;
    localparam logic [3:0] POST_RST = 4'h0;
    localparam logic [2:0] FLT_NONE  = 3'h0;
    localparam logic [2:0] FLT_TIMER = 3'h6;
    localparam logic [1:0] SF_READY = 2'h0;
    localparam logic [1:0] SF_CHG   = 2'h1;
    localparam logic [1:0] SF_DONE  = 2'h2;
    localparam logic [1:0] SF_FAULT = 2'h3;
    // Comparator flag positions.
    localparam int NF = 11;
    localparam int F_PRES = 0, F_WIN = 1, F_EXIT = 2, F_WEAK = 3, F_SHORT = 4;
    localparam int F_3V0 = 5, F_RCH = 6, F_SYSLO = 7, F_SYSHI = 8, F_TERM = 9;
    localparam int F_SLEEP = 10;
    // Currents in mA and levels in mV.
    localparam logic [10:0] CHG_BASE_MA = 11'h226;
    localparam logic [10:0] CHG_STEP_MA = 11'h064;
    localparam logic [10:0] CHG_MAX_MA  = 11'h60E;
    localparam logic [3:0]  CHG_TOP_CODE = 4'h9;
    localparam logic [10:0] LOW_MA   = 11'h154;
    localparam logic [10:0] SHORT_LO = 11'h00D;
    localparam logic [10:0] SHORT_HI = 11'h01E;
    localparam logic [8:0]  TERM_STEP_MA = 9'h032;
    localparam logic [11:0] EXIT_100_MV = 12'hD48;
    localparam logic [11:0] EXIT_500_MV = 12'hCE4;
    localparam logic [11:0] EXIT_HI_MV  = 12'hC80;
    // Times as printed and derived clock counts.
    localparam longint unsigned UNATT_MIN = 15;
    localparam longint unsigned HOST_S    = 32;
    localparam longint unsigned CONN_MS   = 256;
    localparam longint unsigned VALID_MS  = 32;
    localparam longint unsigned UNATT_CYC = UNATT_MIN * 60 * CLK_HZ;
    localparam longint unsigned HOST_CYC  = HOST_S * CLK_HZ;
    localparam longint unsigned CONN_CYC  = CONN_MS * CLK_HZ / 1000;
    localparam longint unsigned VALID_CYC = VALID_MS * CLK_HZ / 1000;
    typedef enum logic [2:0] {
        ST_IDLE, ST_VALID, ST_PPATH, ST_PWM, ST_POST, ST_DONE, ST_FAULT
    } csc_state_t;
endpackage : csc_pkg
`default_nettype wire

// File: csc_charge_seq.sv
// Charge sequence controller: mode state machine, safety and host timers,
// input validation, current decoding and path switch control.
// Assumes comparator flags from the analog side and a host register port.
//
// Function
// - Charge code 0..9 gives 550..1450 mA by 100 mA; 10..15 give 1550 mA.
// - Fixed-low select, set at reset, overrides the code with 340 mA.
// - Current termination happens only while termination enable is one; here post-charge ends at termination current whatever its value.
// - Termination and post-charge codes 0..7 give 50..400 mA by 50 mA.
// - Below termination current, stop PWM, raise status, report charge done.
// - With post-charge enabled, top-off follows termination with active flag set.
// - Status high in post-charge; leave only on POR, good cycle, control toggle; here also left at post termination, below 3.0 V, on timer expiry.
// - Fifteen-minute unattended timer at charge start; expiry stops, fault 110.
// - Any host write stops and clears unattended timer, starts host timer.
// - Writing the timer kick bit restarts the host timer from zero.
// - Host timer expiry reloads defaults and resumes charging unattended.
// - Pulse status and set input-connected flag 256 ms after input appears.
// - Input must stay valid 32 ms before charging; repeated before heavy draw.
// - At POR keep registers if battery strong, else reload when host idle.
// - Auto-charge variant starts alone; other variant idles with switches on.
// - Below exit level run linear power path, 340 mA, battery-good high.
// - Exit level is 3.4 V, 3.3 V or 3.2 V by input current limit.
// - Below short level path current is 13 mA or 30 mA by input limit.
// - In PWM, rail 5 mV below battery turns bypass on until rail recovers.
// - Battery-good drops at weak level, stays low in PWM, PWM ends below 3.0 V.
// - With controls low, recharge margin or a host write starts a new charge.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module csc_charge_seq
    import csc_pkg::*;
#(
    parameter bit          AUTO_CHARGE = 1'b1,
    parameter logic [39:0] P_UNATT_CYC = 40'(UNATT_CYC),
    parameter logic [39:0] P_HOST_CYC  = 40'(HOST_CYC),
    parameter logic [39:0] P_CONN_CYC  = 40'(CONN_CYC),
    parameter logic [39:0] P_VALID_CYC = 40'(VALID_CYC)
) (
    // Clock, reset and enable
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          clk_en,
    // Register port
    input  wire logic [2:0]    addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic          wr_en,
    input  wire logic          rd_en,
    output var  logic [7:0]    rd_data,
    // Analog comparator flags and control pin
    input  wire logic [NF-1:0] cmp_flags,
    input  wire logic          disable_pin,
    // Regulator and path controls
    output var  logic          pwm_enable,
    output var  logic          path_linear,
    output var  logic          path_switch,
    output var  logic          bypass_switch_n,
    output var  logic [10:0]   charge_limit_ma,
    output var  logic [8:0]    term_limit_ma,
    output var  logic [11:0]   exit_level_mv,
    output var  logic          sys_power_en,
    // Status
    output var  logic          battery_good_n,
    output var  logic          status_pin
);

    function automatic logic [10:0] chg_ma(input logic [3:0] code);
        return (code > CHG_TOP_CODE) ? CHG_MAX_MA
                                     : 11'(CHG_BASE_MA + CHG_STEP_MA * 11'(code));
    endfunction : chg_ma

    function automatic logic [8:0] term_ma(input logic [2:0] code);
        return 9'(TERM_STEP_MA * (9'(code) + 9'h001));
    endfunction : term_ma

    // Two-stage synchroniser; only the second stage is read.
    logic [NF-1:0] sync1;
    logic [NF-1:0] f;
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1 <= '0;
            f     <= '0;
        end else if (clk_en) begin
            sync1 <= cmp_flags;
            f     <= sync1;
        end
    end

    csc_state_t  st, next_st;
    logic [7:0]  ctl1, next_ctl1;
    logic [7:0]  cur, next_cur;
    logic [3:0]  post, next_post;
    logic [2:0]  fault, next_fault;
    logic        conn, next_conn;
    logic        pc_act, next_pc_act;
    logic [39:0] conn_cnt, next_conn_cnt;
    logic [39:0] val_cnt, next_val_cnt;
    logic        val_ok, next_val_ok;
    logic [39:0] un_cnt, next_un_cnt;
    logic        un_run, next_un_run;
    logic [39:0] h_cnt, next_h_cnt;
    logic        h_run, next_h_run;
    logic        pres_q, next_pres_q;
    logic [1:0]  ctl_q, next_ctl_q;
    logic        byp, next_byp;
    logic        pulse, next_pulse;
    logic [7:0]  next_rd_data;
    logic        next_pwm_enable, next_path_linear, next_path_switch;
    logic        next_bypass_switch_n, next_sys_power_en;
    logic        next_battery_good_n, next_status_pin;
    logic [10:0] next_charge_limit_ma;
    logic [8:0]  next_term_limit_ma;
    logic [11:0] next_exit_level_mv;

    logic por, host_exp, un_exp, chg_ok, charging, ctl_tog, kick, start_chg;
    logic [1:0] sf;

    always_comb begin
        next_st = st;
        next_ctl1 = ctl1;
        next_cur = cur;
        next_post = post;
        next_fault = fault;
        next_conn = conn;
        next_pc_act = pc_act;
        next_conn_cnt = conn_cnt;
        next_val_cnt = val_cnt;
        next_val_ok = val_ok;
        next_un_cnt = un_cnt;
        next_un_run = un_run;
        next_h_cnt = h_cnt;
        next_h_run = h_run;
        next_byp = byp;
        next_pulse = 1'b0;
        next_pres_q = f[F_PRES];
        next_ctl_q = {ctl1[B_CEN], ctl1[B_HZ]};
        por = f[F_PRES] & ~pres_q;
        host_exp = h_run && (h_cnt == P_HOST_CYC - 40'h1);
        un_exp = un_run && (un_cnt == P_UNATT_CYC - 40'h1);
        chg_ok = ~disable_pin & ~ctl1[B_CEN] & ~ctl1[B_HZ];
        charging = (st == ST_PPATH) | (st == ST_PWM) | (st == ST_POST);
        ctl_tog = {ctl1[B_CEN], ctl1[B_HZ]} != ctl_q;
        kick = wr_en && (addr == A_CTL0) && wr_data[B_KICK];
        start_chg = 1'b0;
        if (!f[F_PRES]) begin
            next_conn_cnt = '0;
            next_conn = 1'b0;
        end else if (conn_cnt != P_CONN_CYC) begin
            next_conn_cnt = conn_cnt + 40'h1;
            if (conn_cnt == P_CONN_CYC - 40'h1) begin
                next_conn = 1'b1;
                next_pulse = 1'b1;
            end
        end
        if (!(f[F_PRES] && f[F_WIN])) begin
            next_val_cnt = '0;
            next_val_ok = 1'b0;
        end else if (val_cnt == P_VALID_CYC - 40'h1) begin
            next_val_ok = 1'b1;
        end else begin
            next_val_cnt = val_cnt + 40'h1;
        end
        if (h_run) begin
            next_h_cnt = h_cnt + 40'h1;
        end
        if (un_run) begin
            next_un_cnt = un_cnt + 40'h1;
        end
        if (wr_en) begin
            unique case (addr)
                A_CTL1: next_ctl1 = wr_data;
                A_CUR:  next_cur = wr_data;
                A_POST: next_post = wr_data[3:0];
                default: ;
            endcase
            next_un_run = 1'b0;
            next_un_cnt = '0;
            if (!h_run) begin
                next_h_run = 1'b1;
                next_h_cnt = '0;
            end
        end
        if (kick) begin
            next_h_cnt = '0;
        end
        unique case (st)
            ST_IDLE, ST_FAULT: begin
                if (wr_en && chg_ok) begin
                    next_st = ST_VALID;
                    next_fault = FLT_NONE;
                end
            end
            ST_VALID: begin
                if (val_ok && chg_ok) begin
                    start_chg = 1'b1;
                    next_st = f[F_EXIT] ? ST_PWM : ST_PPATH;
                end
            end
            ST_PPATH: begin
                if (f[F_EXIT]) begin
                    next_st = ST_PWM;
                end
            end
            ST_PWM: begin
                if (!f[F_3V0]) begin
                    next_st = ST_PPATH;
                end else if (ctl1[B_TE] && f[F_TERM]) begin
                    if (post[B_PCEN]) begin
                        next_st = ST_POST;
                        next_pc_act = 1'b1;
                    end else begin
                        next_st = ST_DONE;
                    end
                end
            end
            ST_POST: begin
                if (!f[F_3V0]) begin
                    next_st = ST_PPATH;
                    next_pc_act = 1'b0;
                end else if (f[F_TERM]) begin
                    next_st = ST_DONE;
                    next_pc_act = 1'b0;
                end
            end
            ST_DONE: begin
                if (chg_ok && (f[F_RCH] || wr_en)) begin
                    next_st = ST_VALID;
                    next_val_cnt = '0;
                    next_val_ok = 1'b0;
                end
            end
            default: next_st = ST_IDLE;
        endcase

        // Losing the input window forces a new validation before heavy draw.
        if (charging && !val_ok) begin
            next_st = ST_VALID;
            next_pc_act = 1'b0;
        end
        if (charging && (!chg_ok || ctl_tog)) begin
            next_st = ST_IDLE;
            next_pc_act = 1'b0;
        end
        if (start_chg && !h_run && !wr_en) begin
            next_un_run = 1'b1;
            next_un_cnt = '0;
        end
        if (un_exp && !wr_en) begin
            next_un_run = 1'b0;
            next_st = ST_FAULT;
            next_fault = FLT_TIMER;
            next_pc_act = 1'b0;
        end
        if (host_exp && !kick) begin
            next_h_run = 1'b0;
            next_ctl1 = CTL1_RST;
            next_cur = CUR_RST;
            next_post = POST_RST;
            next_pc_act = 1'b0;
            next_st = ST_VALID;
        end
        if (por) begin
            next_pc_act = 1'b0;
            if (!f[F_WEAK] && !h_run) begin
                next_ctl1 = CTL1_RST;
                next_cur = CUR_RST;
                next_post = POST_RST;
            end
            next_st = AUTO_CHARGE ? ST_VALID : ST_IDLE;
        end
        if (!f[F_PRES]) begin
            next_st = ST_IDLE;
            next_pc_act = 1'b0;
            next_un_run = 1'b0;
        end
        if ((st == ST_PWM) || (st == ST_POST)) begin
            if (f[F_SYSLO]) begin
                next_byp = 1'b1;
            end else if (f[F_SYSHI]) begin
                next_byp = 1'b0;
            end
        end else begin
            next_byp = 1'b0;
        end
        next_pwm_enable = (st == ST_PWM) | (st == ST_POST);
        next_path_linear = (st == ST_PPATH);
        next_path_switch = (st != ST_PPATH);
        next_bypass_switch_n = ~(f[F_SLEEP] | byp
                                 | (!AUTO_CHARGE && (st == ST_IDLE)));
        next_sys_power_en = val_ok;
        next_battery_good_n = battery_good_n;
        if (st == ST_PPATH) begin
            next_battery_good_n = 1'b1;
        end else if (next_pwm_enable && f[F_WEAK]) begin
            next_battery_good_n = 1'b0;
        end
        next_status_pin = pulse | (st == ST_DONE) | (st == ST_POST);
        if (st == ST_PPATH) begin
            if (f[F_SHORT]) begin
                next_charge_limit_ma = LOW_MA;
            end else begin
                next_charge_limit_ma = ctl1[7] ? SHORT_HI : SHORT_LO;
            end
        end else if (cur[B_FIXLO]) begin
            next_charge_limit_ma = LOW_MA;
        end else begin
            next_charge_limit_ma = chg_ma(cur[6:3]);
        end
        next_term_limit_ma = (st == ST_POST) ? term_ma(post[2:0])
                                             : term_ma(cur[2:0]);
        unique case (ctl1[7:6])
            2'h0: next_exit_level_mv = EXIT_100_MV;
            2'h1: next_exit_level_mv = EXIT_500_MV;
            default: next_exit_level_mv = EXIT_HI_MV;
        endcase
        unique case (st)
            ST_DONE:  sf = SF_DONE;
            ST_FAULT: sf = SF_FAULT;
            ST_IDLE, ST_VALID: sf = SF_READY;
            default:  sf = SF_CHG;
        endcase
        next_rd_data = '0;
        if (rd_en) begin
            unique case (addr)
                A_CTL0: next_rd_data = {2'h0, sf, conn, fault};
                A_CTL1: next_rd_data = ctl1;
                A_CUR:  next_rd_data = cur;
                A_POST: next_rd_data = {3'h0, pc_act, post};
                default: next_rd_data = '0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st <= ST_IDLE;
            ctl1 <= CTL1_RST;
            cur <= CUR_RST;
            post <= POST_RST;
            fault <= FLT_NONE;
            conn <= 1'b0;
            pc_act <= 1'b0;
            conn_cnt <= '0;
            val_cnt <= '0;
            val_ok <= 1'b0;
            un_cnt <= '0;
            un_run <= 1'b0;
            h_cnt <= '0;
            h_run <= 1'b0;
            pres_q <= 1'b0;
            ctl_q <= 2'h0;
            byp <= 1'b0;
            pulse <= 1'b0;
            rd_data <= '0;
            pwm_enable <= 1'b0;
            path_linear <= 1'b0;
            path_switch <= 1'b1;
            bypass_switch_n <= 1'b1;
            sys_power_en <= 1'b0;
            battery_good_n <= 1'b1;
            status_pin <= 1'b0;
            charge_limit_ma <= LOW_MA;
            term_limit_ma <= TERM_STEP_MA;
            exit_level_mv <= EXIT_100_MV;
        end else if (clk_en) begin
            st <= next_st;
            ctl1 <= next_ctl1;
            cur <= next_cur;
            post <= next_post;
            fault <= next_fault;
            conn <= next_conn;
            pc_act <= next_pc_act;
            conn_cnt <= next_conn_cnt;
            val_cnt <= next_val_cnt;
            val_ok <= next_val_ok;
            un_cnt <= next_un_cnt;
            un_run <= next_un_run;
            h_cnt <= next_h_cnt;
            h_run <= next_h_run;
            pres_q <= next_pres_q;
            ctl_q <= next_ctl_q;
            byp <= next_byp;
            pulse <= next_pulse;
            rd_data <= next_rd_data;
            pwm_enable <= next_pwm_enable;
            path_linear <= next_path_linear;
            path_switch <= next_path_switch;
            bypass_switch_n <= next_bypass_switch_n;
            sys_power_en <= next_sys_power_en;
            battery_good_n <= next_battery_good_n;
            status_pin <= next_status_pin;
            charge_limit_ma <= next_charge_limit_ma;
            term_limit_ma <= next_term_limit_ma;
            exit_level_mv <= next_exit_level_mv;
        end
    end

endmodule : csc_charge_seq
`default_nettype wire

// File: csc_charge_seq_chk.sv
// Port checks for the charge sequence controller, bound to every instance.
// Assumes clk_en stays high while the checks run.
`timescale 1ns/10ps
`default_nettype none
module csc_charge_seq_chk
    import csc_pkg::*;
(
    // Clock, reset and register port
    input wire logic          clock,
    input wire logic          rst,
    input wire logic [2:0]    addr,
    input wire logic [7:0]    wr_data,
    input wire logic          wr_en,
    input wire logic          rd_en,
    input wire logic [7:0]    rd_data,
    // Flags and controls
    input wire logic [NF-1:0] cmp_flags,
    input wire logic          pwm_enable,
    input wire logic          path_linear,
    input wire logic          path_switch,
    input wire logic          bypass_switch_n,
    input wire logic [10:0]   charge_limit_ma,
    input wire logic [8:0]    term_limit_ma,
    input wire logic [11:0]   exit_level_mv,
    input wire logic          battery_good_n,
    input wire logic          status_pin
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    function automatic logic [10:0] chg_ma(input logic [7:0] d);
        if (d[7])
            return LOW_MA;
        if (d[6:3] > CHG_TOP_CODE)
            return CHG_MAX_MA;
        return CHG_BASE_MA + CHG_STEP_MA * 11'(d[6:3]);
    endfunction : chg_ma
    function automatic logic [8:0] term_ma(input logic [7:0] d);
        return TERM_STEP_MA * (9'(d[2:0]) + 9'h001);
    endfunction : term_ma
    function automatic logic [11:0] exit_mv(input logic [7:0] d);
        return d[7:6] == 2'h0 ? EXIT_100_MV : d[7:6] == 2'h1 ? EXIT_500_MV : EXIT_HI_MV;
    endfunction : exit_mv
    a_reset_vals: assert property (
        $fell(rst) |-> path_switch && bypass_switch_n && battery_good_n && !pwm_enable
            && !status_pin && charge_limit_ma == LOW_MA && exit_level_mv == EXIT_100_MV)
        else $error("outputs wrong after reset");
    a_charge_code: assert property (
        wr_en && addr == A_CUR |-> ##2 (!pwm_enable
            || charge_limit_ma == chg_ma($past(wr_data, 2))))
        else $error("charge limit wrong for code");
    a_term_code: assert property (
        wr_en && addr == A_CUR |-> ##2 (!pwm_enable || status_pin
            || term_limit_ma == term_ma($past(wr_data, 2))))
        else $error("termination limit wrong for code");
    a_exit_level: assert property (
        wr_en && addr == A_CTL1 |-> ##2 exit_level_mv == exit_mv($past(wr_data, 2)))
        else $error("exit level wrong for input limit");
    a_path_mode: assert property (
        path_linear |-> battery_good_n && !path_switch && charge_limit_ma <= LOW_MA)
        else $error("power path outputs wrong");
    a_bypass_on: assert property (
        (pwm_enable && cmp_flags[F_SYSLO] && !cmp_flags[F_SYSHI]) [*5] |-> !bypass_switch_n)
        else $error("bypass not on with rail low");
    a_bypass_off: assert property (
        (pwm_enable && cmp_flags[F_SYSHI] && !cmp_flags[F_SYSLO]) [*5] |-> bypass_switch_n)
        else $error("bypass not off with rail high");
    a_good_pwm: assert property (
        (pwm_enable && cmp_flags[F_WEAK] && cmp_flags[F_3V0]) [*5] |-> !battery_good_n)
        else $error("battery good not low in pwm");
    a_read_idle: assert property (
        !$past(rd_en) |-> rd_data == 8'h00)
        else $error("read data outside read slot");
endmodule : csc_charge_seq_chk
bind csc_charge_seq csc_charge_seq_chk i_chk (
    .clock, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .cmp_flags,
    .pwm_enable, .path_linear, .path_switch, .bypass_switch_n, .charge_limit_ma,
    .term_limit_ma, .exit_level_mv, .battery_good_n, .status_pin
);
`default_nettype wire

// File: csc_host_model.sv
// Host software model: one-cycle write and read strobes on the register port.
// Assumes read data stand in the cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
module csc_host_model
    import csc_pkg::*;
(
    // Register port
    input  wire logic       clock,
    output var  logic [2:0] addr,
    output var  logic [7:0] wr_data,
    output var  logic       wr_en,
    output var  logic       rd_en,
    input  wire logic [7:0] rd_data
);
    initial begin
        addr = 3'h0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        addr <= ~a;
        wr_data <= ~v;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        addr <= ~a;
        #1;
        v = rd_data;
    endtask : rd
    // Software keeps its settings only by kicking before each expiry.
    task automatic kick();
        wr(A_CTL0, 8'h80);
    endtask : kick
endmodule : csc_host_model
`default_nettype wire

// File: csc_charge_seq_tb.sv
// Self-checking bench for the charge sequence controller with a host model.
// Assumes the shortened timer counts set at the instance below.
`timescale 1ns/10ps
`default_nettype none
module csc_charge_seq_tb
    import csc_pkg::*;
;
    localparam int UC = 200, HC = 100, CC = 20, VC = 10;
    logic          clock, rst, clk_en, wr_en, rd_en, disable_pin;
    logic [2:0]    addr;
    logic [7:0]    wr_data, rd_data, d;
    logic [NF-1:0] cmp_flags;
    logic          pwm_enable, path_linear, path_switch, bypass_switch_n;
    logic          sys_power_en, battery_good_n, status_pin;
    logic [10:0]   charge_limit_ma;
    logic [8:0]    term_limit_ma;
    logic [11:0]   exit_level_mv;
    logic [3:0]    cv [4] = '{4'h0, 4'h9, 4'hA, 4'hF};
    int            n_errors = 0;
    int            cmp_count = 0;
    int            cycles = 0;
    int            i;
    csc_host_model i_host (.clock, .addr, .wr_data, .wr_en, .rd_en, .rd_data);
    csc_charge_seq #(
        .AUTO_CHARGE(1'b1), .P_UNATT_CYC(40'(UC)), .P_HOST_CYC(40'(HC)),
        .P_CONN_CYC(40'(CC)), .P_VALID_CYC(40'(VC))
    ) i_dut (
        .clock, .rst, .clk_en, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .cmp_flags,
        .disable_pin, .pwm_enable, .path_linear, .path_switch, .bypass_switch_n,
        .charge_limit_ma, .term_limit_ma, .exit_level_mv, .sys_power_en,
        .battery_good_n, .status_pin
    );
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        i_host.rd(a, d);
        chk($sformatf("reg%0d", a), 12'(e), 12'(d & m));
    endtask : rdc
    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc_wait
    task automatic setf(input int b, input logic v);
        @(posedge clock);
        cmp_flags[b] <= v;
    endtask : setf
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        disable_pin = 1'b0;
        cmp_flags = '0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        cyc_wait(1);
        chk("charge_limit", 12'(LOW_MA), 12'(charge_limit_ma));
        rdc(A_CTL1, 8'hFF, CTL1_RST);
        rdc(A_CUR, 8'hFF, CUR_RST);
        rdc(3'h2, 8'hFF, 8'h00);
        // Input arrives with a flat battery.
        @(posedge clock);
        cmp_flags <= 11'h003;
        cyc_wait(VC - 1);
        chk("sys_power_en", 12'h000, 12'(sys_power_en));
        for (i = VC - 1; i < CC + 20 && status_pin !== 1'b1; i++)
            cyc_wait(1);
        chk("connect_time", 12'h001, 12'(i >= CC - 1 && i <= CC + 8));
        cyc_wait(1);
        chk("status_pulse", 12'h000, 12'(status_pin));
        rdc(A_CTL0, 8'h08, 8'h08);
        for (i = 0; i < 40 && path_linear !== 1'b1; i++)
            cyc_wait(1);
        chk("sys_power_en", 12'h001, 12'(sys_power_en));
        chk("power_path", 12'h006, 12'({path_linear, battery_good_n, path_switch}));
        for (int c = 0; c < 4; c++) begin
            i_host.wr(A_CTL1, {2'(c), 6'h08});
            cyc_wait(2);
            chk("exit_level", c == 0 ? EXIT_100_MV : c == 1 ? EXIT_500_MV : EXIT_HI_MV,
                exit_level_mv);
            chk("short_current", 12'(c < 2 ? SHORT_LO : SHORT_HI), 12'(charge_limit_ma));
        end
        @(posedge clock);
        cmp_flags <= 11'h13F;
        i_host.kick();
        for (i = 0; i < 40 && pwm_enable !== 1'b1; i++)
            cyc_wait(1);
        cyc_wait(4);
        chk("pwm_switches", 12'h002, 12'({path_switch, battery_good_n}));
        setf(F_SYSHI, 1'b0);
        setf(F_SYSLO, 1'b1);
        cyc_wait(5);
        chk("bypass_n", 12'h000, 12'(bypass_switch_n));
        setf(F_SYSLO, 1'b0);
        setf(F_SYSHI, 1'b1);
        cyc_wait(5);
        chk("bypass_n", 12'h001, 12'(bypass_switch_n));
        i_host.kick();
        foreach (cv[j]) begin
            i_host.wr(A_CUR, {1'b0, cv[j], 3'(j * 7)});
            cyc_wait(2);
            chk("charge_limit", cv[j] > CHG_TOP_CODE ? 12'(CHG_MAX_MA)
                : 12'(CHG_BASE_MA + CHG_STEP_MA * 11'(cv[j])), 12'(charge_limit_ma));
            chk("term_limit", 12'(TERM_STEP_MA * 9'(j * 7 % 8 + 1)), 12'(term_limit_ma));
        end
        i_host.wr(A_CUR, 8'h87);
        i_host.wr(A_POST, 8'h09);
        cyc_wait(2);
        chk("term_limit", 12'(8 * TERM_STEP_MA), 12'(term_limit_ma));
        chk("charge_limit", 12'(LOW_MA), 12'(charge_limit_ma));
        i_host.kick();
        // A one-cycle dip, since the sensed level moves once the limit drops.
        setf(F_TERM, 1'b1);
        setf(F_TERM, 1'b0);
        cyc_wait(8);
        chk("post_charge", 12'h003, 12'({pwm_enable, status_pin}));
        chk("term_limit", 12'(2 * TERM_STEP_MA), 12'(term_limit_ma));
        rdc(A_POST, 8'hFF, 8'h19);
        setf(F_TERM, 1'b1);
        cyc_wait(8);
        chk("charge_done", 12'h001, 12'({pwm_enable, status_pin}));
        rdc(A_POST, 8'hFF, 8'h09);
        rdc(A_CTL0, 8'h30, 8'h20);
        setf(F_TERM, 1'b0);
        cyc_wait(HC + 20);
        rdc(A_CUR, 8'hFF, CUR_RST);
        rdc(A_POST, 8'hFF, 8'(POST_RST));
        for (i = 0; i < 40 && pwm_enable !== 1'b1; i++)
            cyc_wait(1);
        chk("resumed", 12'h001, 12'(pwm_enable));
        chk("exit_level", EXIT_100_MV, exit_level_mv);
        for (i = 0; i < 60; i++) begin
            i_host.rd(A_CTL0, d);
            if (d[2:0] === FLT_TIMER)
                break;
            cyc_wait(5);
        end
        chk("fault", 12'(FLT_TIMER), 12'(d[2:0]));
        chk("fault_time", 12'h001, 12'(i >= UC / 12));
        chk("pwm_enable", 12'h000, 12'(pwm_enable));
        end_of_test();
    end
endmodule : csc_charge_seq_tb
`default_nettype wire
